// >>> design/sfcr_device.sv
// Flash device end: continuous array read command front end
`timescale 1ns/1ns
module sfcr_device
  import sfcr_pkg::*;
(
  input  wire logic        i_sys_clk,   // System clock
  input  wire logic        i_rst,       // Sync reset, active high
  sfcr_spi_if.dev          link,        // Serial link pins
  input  wire logic        i_page_512,  // Page size select, 1 = 512
  output logic [12:0]      o_mem_page,  // Array page being read
  output logic [9:0]       o_mem_byte,  // Byte within that page
  input  wire logic [7:0]  i_mem_data,  // Array byte at page/byte
  output logic             o_streaming  // Data phase active, sys clock
);

  // ****************************************
  // Types and signals
  // ****************************************
  typedef enum logic [2:0] {
    ST_OPC,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfcr_dev_state_t;

  sfcr_dev_state_t state_reg;
  logic            frame_rst;
  logic [2:0]      bit_cnt_reg;
  logic [1:0]      byte_cnt_reg;
  logic [2:0]      dummy_total_reg;
  logic [6:0]      shift_reg;
  logic [15:0]     addr_hi_reg;
  logic [12:0]     page_reg;
  logic [9:0]      byte_reg;
  logic            page_sync1_reg;
  logic            page_sync2_reg;
  logic [7:0]      rx_byte;
  logic            byte_done;
  logic [23:0]     full_addr;
  logic [9:0]      last_byte;
  logic            so_reg;
  logic            oe_reg;
  logic [6:0]      out_sr_reg;
  logic            strm_sync1_reg;
  logic            strm_sync2_reg;

  // ****************************************
  // Frame reset
  // ****************************************

  // Deselect or reset pin clears every link flop
  assign frame_rst = link.cs_n | ~link.reset_n;

  // ****************************************
  // Input assembly
  // ****************************************

  // Incoming byte, newest bit in the low position
  always_comb begin
    rx_byte   = {shift_reg, link.si};
    byte_done = (bit_cnt_reg == 3'h7);
    full_addr = {addr_hi_reg, rx_byte};
    last_byte = page_sync2_reg ? SFCR_LAST_BYTE_NARROW : SFCR_LAST_BYTE_WIDE;
  end

  // Page size select crosses into the link clock
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      page_sync1_reg <= 1'b0;
      page_sync2_reg <= 1'b0;
    end else begin
      page_sync1_reg <= i_page_512;
      page_sync2_reg <= page_sync1_reg;
    end
  end

  // Bit counter and input shifter, rising edge sampling
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= rx_byte[6:0];
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************

  // Opcode, address, dummy and data phases
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      state_reg       <= ST_OPC;
      byte_cnt_reg    <= 2'h0;
      dummy_total_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_OPC: begin
          if (byte_done) begin
            if (rx_byte == SFCR_OPC_LEGACY) begin
              dummy_total_reg <= SFCR_DUMMY_LEGACY;
              state_reg       <= ST_ADDR;
            end else if (rx_byte == SFCR_OPC_FAST) begin
              dummy_total_reg <= SFCR_DUMMY_FAST;
              state_reg       <= ST_ADDR;
            end else begin
              state_reg       <= ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (byte_cnt_reg == SFCR_ADDR_BYTES - 2'h1) begin
              byte_cnt_reg <= 2'h0;
              state_reg    <= ST_DUMMY;
            end else begin
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
            end
          end
        end
        ST_DUMMY: begin
          // Dummy contents are never looked at
          if (byte_done) begin
            if ({1'b0, byte_cnt_reg} == dummy_total_reg - 3'h1) begin
              byte_cnt_reg <= 2'h0;
              state_reg    <= ST_DATA;
            end else begin
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
            end
          end
        end
        ST_DATA: begin
          state_reg <= ST_DATA;
        end
        ST_IGNORE: begin
          state_reg <= ST_IGNORE;
        end
        default: begin
          state_reg <= ST_IGNORE;
        end
      endcase
    end
  end

  // ****************************************
  // Address decode and read counter
  // ****************************************

  // First two address bytes held until the third arrives
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      addr_hi_reg <= 16'h0000;
    end else if (state_reg == ST_ADDR && byte_done) begin
      addr_hi_reg <= {addr_hi_reg[7:0], rx_byte};
    end
  end

  // Page and byte pointer straight into the main array
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      page_reg <= 13'h0000;
      byte_reg <= 10'h000;
    end else if (state_reg == ST_ADDR && byte_done &&
                 byte_cnt_reg == SFCR_ADDR_BYTES - 2'h1) begin
      if (page_sync2_reg) begin
        // Narrow page, padding bits above 21 dropped
        page_reg <= full_addr[SFCR_NARROW_PAGE_LSB +: SFCR_PAGE_BITS];
        byte_reg <= {1'b0, full_addr[SFCR_BYTE_BITS_NARROW-1:0]};
      end else begin
        // Wide page, padding bit 23 dropped
        page_reg <= full_addr[SFCR_WIDE_PAGE_LSB +: SFCR_PAGE_BITS];
        byte_reg <= full_addr[SFCR_BYTE_BITS_WIDE-1:0];
      end
    end else if (state_reg == ST_DATA && bit_cnt_reg == 3'h0) begin
      // Step on the first bit of each byte, so the next byte load
      // already sees the new address through the output flops
      if (byte_reg >= last_byte) begin
        byte_reg <= 10'h000;
        page_reg <= page_reg + 13'h0001;
      end else begin
        byte_reg <= byte_reg + 10'h001;
      end
    end
  end

  // Array is addressed directly, buffers never touched
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      o_mem_page <= 13'h0000;
      o_mem_byte <= 10'h000;
    end else begin
      o_mem_page <= page_reg;
      o_mem_byte <= byte_reg;
    end
  end

  // ****************************************
  // Output shifter, falling edge drive
  // ****************************************

  // Byte loaded at bit zero, then shifted out MSB first
  always_ff @(negedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_reg     <= 1'b0;
      oe_reg     <= 1'b0;
      out_sr_reg <= 7'h00;
    end else if (state_reg == ST_DATA) begin
      oe_reg <= 1'b1;
      if (bit_cnt_reg == 3'h0) begin
        so_reg     <= i_mem_data[7];
        out_sr_reg <= i_mem_data[6:0];
      end else begin
        so_reg     <= out_sr_reg[6];
        out_sr_reg <= {out_sr_reg[5:0], 1'b0};
      end
    end
  end

  assign link.so_out = so_reg;
  assign link.so_oe  = oe_reg;

  // ****************************************
  // Status into the system clock
  // ****************************************

  // Output enable flag synchronised for local status
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      strm_sync1_reg <= 1'b0;
      strm_sync2_reg <= 1'b0;
      o_streaming    <= 1'b0;
    end else begin
      strm_sync1_reg <= oe_reg;
      strm_sync2_reg <= strm_sync1_reg;
      o_streaming    <= strm_sync2_reg;
    end
  end

endmodule

// >>> design/sfcr_pkg.sv
// Shared constants for the serial flash continuous read front end
//
// Summary of operation
// - Instruction starts at chip-select fall, 8-bit opcode
// - All bits travel most significant first
// - Three address bytes, padding plus address bits
// - Wide page: buffer byte from 10 bits
// - Wide page: 13 page bits, 10 byte bits
// - Narrow page: buffer byte from 9 bits
// - Narrow page: bits 21..9 page, 8..0 byte
// - Legacy read: opcode, 3 address, 4 dummy
// - Data shifts out only after last dummy
// - Read address counter advances by itself
// - Host holds select low whole transfer
// - Page end continues at next page, gapless
// - Array end wraps to first page, gapless
// - Select rise ends read, output released
// - Reads bypass buffers, buffers unchanged
// - Fast read: opcode, 3 address, 2 dummy
// - Hosts should prefer fast over legacy read
// - Works in clock mode 0 and 3
// - Sample on rising, drive on falling edge
// - Low reset pin aborts, holds idle
// - Deselected: input ignored, output released
package sfcr_pkg;
  // ****************************************
  // Command set
  // ****************************************
  localparam logic [7:0] SFCR_OPC_LEGACY   = 8'he8;
  localparam logic [7:0] SFCR_OPC_FAST     = 8'h1b;
  localparam logic [2:0] SFCR_DUMMY_LEGACY = 3'h4;
  localparam logic [2:0] SFCR_DUMMY_FAST   = 3'h2;
  localparam logic [1:0] SFCR_ADDR_BYTES   = 2'h3;
  // ****************************************
  // Address layout
  // ****************************************
  localparam int         SFCR_PAGE_BITS        = 13;
  localparam int         SFCR_BYTE_BITS_WIDE   = 10;
  localparam int         SFCR_BYTE_BITS_NARROW = 9;
  localparam int         SFCR_WIDE_PAGE_LSB    = 10;
  localparam int         SFCR_NARROW_PAGE_LSB  = 9;
  localparam logic [9:0] SFCR_LAST_BYTE_WIDE   = 10'h20f;
  localparam logic [9:0] SFCR_LAST_BYTE_NARROW = 10'h1ff;
  // ****************************************
  // Link timing
  // ****************************************
  localparam int         SFCR_HALF_DIV_DEF     = 4;
  localparam int         SFCR_BYTE_BITS        = 8;
endpackage

// >>> design/sfcr_spi_if.sv
// Serial link between the flash device end and the host end
`timescale 1ns/1ns
interface sfcr_spi_if;
  logic cs_n;     // Chip select, active low
  logic sck;      // Serial clock from host
  logic si;       // Host to device data
  logic so_out;   // Device output value
  logic so_oe;    // Device output enable
  logic reset_n;  // Device reset pin, active low
  logic so_line;  // Resolved output wire level

  // Released line floats to the pull-up level
  assign so_line = so_oe ? so_out : 1'b1;

  modport dev (
    input  cs_n, sck, si, reset_n,
    output so_out, so_oe
  );
  modport host (
    output cs_n, sck, si, reset_n,
    input  so_line
  );
endinterface

// >>> design/sfcr_host.sv
// Host end: serial master issuing continuous array reads
`timescale 1ns/1ns
module sfcr_host
  import sfcr_pkg::*;
#(
  parameter int HALF_DIV = SFCR_HALF_DIV_DEF,  // System clocks per half sck
  parameter bit MODE3    = 1'b0                // Clock idles high when set
)(
  input  wire logic        i_sys_clk,     // System clock
  input  wire logic        i_rst,         // Sync reset, active high
  input  wire logic        i_start,       // Start a read, one pulse
  input  wire logic        i_fast,        // 1 = fast opcode, 0 = legacy
  input  wire logic [23:0] i_addr,        // Three address bytes
  input  wire logic [15:0] i_count,       // Bytes to read
  output logic             o_busy,        // Transfer in progress
  output logic [7:0]       o_data,        // Received byte
  output logic             o_data_valid,  // Received byte strobe
  sfcr_spi_if.host         link           // Serial link pins
);

  // ****************************************
  // Types and signals
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_TAIL,
    ST_END
  } sfcr_host_state_t;

  sfcr_host_state_t state_reg;
  logic [7:0]       div_cnt_reg;
  logic             half_tick;
  logic             sck_reg;
  logic             cs_n_reg;
  logic             si_reg;
  logic             rst_n_reg;
  logic [63:0]      tx_sr_reg;
  logic             pending_reg;
  logic [19:0]      bit_cnt_reg;
  logic [19:0]      total_reg;
  logic [19:0]      tx_bits_reg;
  logic [7:0]       rx_sr_reg;
  logic [2:0]       rx_cnt_reg;
  logic             so_sync1_reg;
  logic             so_sync2_reg;
  logic             rise;

  // Opcode, address and dummy bits ahead of the data phase
  localparam logic [19:0] TX_BITS_FAST =
    20'(SFCR_BYTE_BITS * (1 + SFCR_ADDR_BYTES + SFCR_DUMMY_FAST));
  localparam logic [19:0] TX_BITS_LEGACY =
    20'(SFCR_BYTE_BITS * (1 + SFCR_ADDR_BYTES + SFCR_DUMMY_LEGACY));

  assign half_tick = (div_cnt_reg == 8'(HALF_DIV - 1));
  assign rise      = (state_reg == ST_RUN) && half_tick && !sck_reg;

  // ****************************************
  // Sequencer and clock divider
  // ****************************************

  // Select and clock framing of one transfer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg   <= ST_IDLE;
      div_cnt_reg <= 8'h00;
      sck_reg     <= MODE3;
      cs_n_reg    <= 1'b1;
      o_busy      <= 1'b0;
      bit_cnt_reg <= 20'h00000;
    end else begin
      div_cnt_reg <= half_tick ? 8'h00 : div_cnt_reg + 8'h01;
      case (state_reg)
        ST_IDLE: begin
          sck_reg <= MODE3;
          if (i_start) begin
            cs_n_reg    <= 1'b0;
            o_busy      <= 1'b1;
            bit_cnt_reg <= 20'h00000;
            div_cnt_reg <= 8'h00;
            state_reg   <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (half_tick) begin
            sck_reg <= ~sck_reg;
            if (!sck_reg) begin
              bit_cnt_reg <= bit_cnt_reg + 20'h00001;
              if (bit_cnt_reg == total_reg - 20'h00001) begin
                state_reg <= ST_TAIL;
              end
            end
          end
        end
        ST_TAIL: begin
          if (half_tick) begin
            sck_reg   <= MODE3;
            state_reg <= ST_END;
          end
        end
        ST_END: begin
          // Select held low until the final clock settles
          if (half_tick) begin
            cs_n_reg  <= 1'b1;
            o_busy    <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************

  // Frame image: opcode, address, zero dummies
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_sr_reg   <= 64'h0;
      si_reg      <= 1'b0;
      pending_reg <= 1'b0;
      total_reg   <= 20'h00000;
      tx_bits_reg <= 20'h00000;
    end else if (state_reg == ST_IDLE && i_start) begin
      // Opcode for new transfers chosen by i_fast, fast or legacy
      tx_sr_reg   <= {(i_fast ? SFCR_OPC_FAST : SFCR_OPC_LEGACY), i_addr, 32'h0};
      si_reg      <= i_fast ? SFCR_OPC_FAST[7] : SFCR_OPC_LEGACY[7];
      pending_reg <= 1'b0;
      tx_bits_reg <= i_fast ? TX_BITS_FAST : TX_BITS_LEGACY;
      total_reg   <= (i_fast ? TX_BITS_FAST : TX_BITS_LEGACY) + {1'b0, i_count, 3'h0};
    end else if (state_reg == ST_RUN && half_tick) begin
      if (!sck_reg) begin
        pending_reg <= 1'b1;
      end else if (pending_reg) begin
        // Next bit placed on the falling edge
        tx_sr_reg   <= {tx_sr_reg[62:0], 1'b0};
        si_reg      <= tx_sr_reg[62];
        pending_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Receive path
  // ****************************************

  // Device output resynchronised before sampling
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      so_sync1_reg <= 1'b1;
      so_sync2_reg <= 1'b1;
    end else begin
      so_sync1_reg <= link.so_line;
      so_sync2_reg <= so_sync1_reg;
    end
  end

  // Bits gathered after the dummy phase, MSB first
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_sr_reg    <= 8'h00;
      rx_cnt_reg   <= 3'h0;
      o_data       <= 8'h00;
      o_data_valid <= 1'b0;
    end else begin
      o_data_valid <= 1'b0;
      if (state_reg == ST_IDLE) begin
        rx_cnt_reg <= 3'h0;
      end else if (rise && bit_cnt_reg >= tx_bits_reg) begin
        rx_sr_reg  <= {rx_sr_reg[6:0], so_sync2_reg};
        rx_cnt_reg <= rx_cnt_reg + 3'h1;
        if (rx_cnt_reg == 3'h7) begin
          o_data       <= {rx_sr_reg[6:0], so_sync2_reg};
          o_data_valid <= 1'b1;
        end
      end
    end
  end

  // Device reset pin follows the host reset
  always_ff @(posedge i_sys_clk) begin
    rst_n_reg <= ~i_rst;
  end

  assign link.cs_n    = cs_n_reg;
  assign link.sck     = sck_reg;
  assign link.si      = si_reg;
  assign link.reset_n = rst_n_reg;

endmodule

// >>> bench/sfcr_checker.sv
// Link checker for the continuous read serial interface
`timescale 1ns/1ns
module sfcr_checker (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst,     // Sync reset, active high
  input wire logic cs_n,      // Chip select, active low
  input wire logic sck,       // Serial clock
  input wire logic si,        // Host to device data
  input wire logic so_out,    // Device output value
  input wire logic so_oe,     // Device output enable
  input wire logic reset_n    // Device reset pin, active low
);
  // ********************
  // Frame tracking
  // ********************
  logic       sck_reg;
  logic [7:0] rise_cnt_reg;
  logic [7:0] opc_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // Count clock rises in a frame, capture the opcode
  always_ff @(posedge i_sys_clk) begin
    sck_reg <= sck;
    if (i_rst || cs_n) begin
      rise_cnt_reg <= 8'h00;
      opc_reg      <= 8'h00;
    end else if (sck && !sck_reg) begin
      rise_cnt_reg <= rise_cnt_reg + 8'h01;
      if (rise_cnt_reg < 8'h08) begin
        opc_reg <= {opc_reg[6:0], si};
      end
    end
  end

  // ********************
  // Link properties
  // ********************
  sequence s_select; $fell(cs_n) ##1 !cs_n [*3]; endsequence
  sequence s_first_drive; $rose(so_oe) ##0 $fell(sck); endsequence

  property p_idle_quiet; cs_n |-> !so_oe; endproperty
  property p_lead_in; s_select |-> !so_oe; endproperty
  property p_first_data;
    $rose(so_oe) |-> (opc_reg == 8'he8 && rise_cnt_reg == 8'h40) ||
                     (opc_reg == 8'h1b && rise_cnt_reg == 8'h30);
  endproperty
  property p_on_fall; $rose(so_oe) |-> s_first_drive; endproperty
  property p_hold_bits;
    (so_oe && $past(so_oe) && !$fell(sck)) |-> $stable(so_out);
  endproperty
  property p_end_release; $fell(so_oe) |-> (cs_n || !reset_n); endproperty
  property p_reset_pin; !reset_n |-> !so_oe; endproperty
  property p_clock_framed; $changed(sck) |-> !cs_n; endproperty
  property p_mode0_idle; cs_n |-> !sck; endproperty

  a_idle_quiet: assert property (p_idle_quiet) else $error("output on while deselected");
  a_lead_in: assert property (p_lead_in) else $error("output on during command");
  a_first_data: assert property (p_first_data) else $error("data start wrong");
  a_on_fall: assert property (p_on_fall) else $error("drive not on clock fall");
  a_hold_bits: assert property (p_hold_bits) else $error("output moved off fall");
  a_end_release: assert property (p_end_release) else $error("read ended early");
  a_reset_pin: assert property (p_reset_pin) else $error("output on in reset");
  a_clock_framed: assert property (p_clock_framed) else $error("clock outside frame");
  a_mode0_idle: assert property (p_mode0_idle) else $error("clock idle not low");
endmodule

// >>> bench/sfcr_tb.sv
// Testbench: host and device ends joined over the serial link
`timescale 1ns/1ns
module serial_flash_continuous_read_tb
  import sfcr_pkg::*;
;
  logic        i_sys_clk; // System clock
  logic        rst;       // Device side reset
  logic        host_rst;  // Host side reset
  logic        start;     // Start pulse
  logic        sel;       // Pair in use, 1 = mode 3
  logic        fast;      // Fast opcode select
  logic        page_512;  // Page size select
  logic [23:0] addr;      // Start address bytes
  logic [15:0] count;     // Bytes to read
  logic [1:0]  busy;      // Host busy per pair
  logic [1:0]  valid;     // Byte strobe per pair
  logic [7:0]  data [2];  // Received byte per pair
  logic [1:0]  stream;    // Device data phase per pair
  int          failures;  // Mismatch count
  int          checks;    // Comparison count

  // ********************
  // Two linked pairs, mode 0 and mode 3
  // ********************
  genvar g;
  for (g = 0; g < 2; g++) begin : pair
    logic [12:0] mem_page;
    logic [9:0]  mem_byte;
    sfcr_spi_if spi ();
    sfcr_host #(.HALF_DIV(4), .MODE3(g == 1)) sfcr_host_inst (
      .i_sys_clk    (i_sys_clk),
      .i_rst        (host_rst),
      .i_start      (start & (sel == 1'(g))),
      .i_fast       (fast),
      .i_addr       (addr),
      .i_count      (count),
      .o_busy       (busy[g]),
      .o_data       (data[g]),
      .o_data_valid (valid[g]),
      .link         (spi.host)
    );
    sfcr_device sfcr_device_inst (
      .i_sys_clk   (i_sys_clk),
      .i_rst       (rst),
      .link        (spi.dev),
      .i_page_512  (page_512),
      .o_mem_page  (mem_page),
      .o_mem_byte  (mem_byte),
      .i_mem_data  (mem_byte[7:0] ^ {mem_page[3:0], 4'h0}),
      .o_streaming (stream[g])
    );
    if (g == 0) begin : watch
      sfcr_checker sfcr_checker_inst (
        .i_sys_clk (i_sys_clk),
        .i_rst     (rst),
        .cs_n      (spi.cs_n),
        .sck       (spi.sck),
        .si        (spi.si),
        .so_out    (spi.so_out),
        .so_oe     (spi.so_oe),
        .reset_n   (spi.reset_n)
      );
    end
  end

  // Free running system clock
  initial i_sys_clk = 1'b0;
  always #5 i_sys_clk = ~i_sys_clk;

  // ********************
  // Tasks
  // ********************
  task automatic check(input string what, input logic [15:0] exp_v, input logic [15:0] got_v);
    checks++;
    if (got_v !== exp_v) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp_v, got_v);
    end
  endtask

  task automatic report_and_stop();
    $display("Counts: checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One read, each byte compared with the stepped address model
  task automatic do_read(input logic f, input logic p5, input logic [23:0] a,
                         input logic [15:0] n, input logic s);
    logic [12:0] pg;
    logic [9:0]  bt;
    logic [15:0] got;
    logic        seen;
    int          w;
    pg = p5 ? a[21:9] : a[22:10];
    bt = p5 ? {1'b0, a[8:0]} : a[9:0];
    got = 16'h0000;
    seen = 1'b0;
    w = 0;
    sel = s;
    fast = f;
    page_512 = p5;
    addr = a;
    count = n;
    start = 1'b1;
    @(posedge i_sys_clk);
    #1;
    start = 1'b0;
    do begin
      @(posedge i_sys_clk);
      #1;
      w++;
      seen = seen | stream[s];
      if (valid[s] === 1'b1) begin
        check("data", {8'h00, bt[7:0] ^ {pg[3:0], 4'h0}}, {8'h00, data[s]});
        got = got + 16'h0001;
        bt = bt + 10'h001;
        if (bt > (p5 ? SFCR_LAST_BYTE_NARROW : SFCR_LAST_BYTE_WIDE)) begin
          bt = 10'h000;
          pg = pg + 13'h0001;
        end
      end
    end while ((busy[s] !== 1'b0 || w < 3) && w < 5000);
    check("in time", 16'h0001, {15'h0000, w < 5000});
    check("bytes", n, got);
    if (n != 16'h0000) begin
      check("streaming", 16'h0001, {15'h0000, seen});
    end
    $display("Test done: read addr %h bytes %0d pair %0d", a, n, s);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    rst = 1'b1;
    host_rst = 1'b1;
    start = 1'b0;
    sel = 1'b0;
    fast = 1'b0;
    page_512 = 1'b0;
    addr = 24'h000000;
    count = 16'h0000;
    failures = 0;
    checks = 0;
    repeat (5) @(posedge i_sys_clk);
    #1;
    rst = 1'b0;
    host_rst = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    do_read(1'b0, 1'b0, {1'b1, 13'h0005, 10'h20e}, 16'h0004, 1'b0);
    do_read(1'b1, 1'b0, {1'b0, 13'h1fff, 10'h20e}, 16'h0003, 1'b0);
    do_read(1'b0, 1'b1, {2'b11, 13'h0003, 9'h1fe}, 16'h0004, 1'b0);
    do_read(1'b1, 1'b1, {2'b10, 13'h1fff, 9'h1ff}, 16'h0002, 1'b0);
    do_read(1'b1, 1'b0, 24'h000000, 16'h0000, 1'b0);
    // Reset pin pulled low in mid data phase
    fast = 1'b1;
    addr = 24'h00a005;
    count = 16'h0008;
    start = 1'b1;
    @(posedge i_sys_clk);
    #1;
    start = 1'b0;
    repeat (400) @(posedge i_sys_clk);
    #1;
    check("stream before", 16'h0001, {15'h0000, stream[0]});
    host_rst = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    host_rst = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    check("busy", 16'h0000, {15'h0000, busy[0]});
    check("stream after", 16'h0000, {15'h0000, stream[0]});
    $display("Test done: abort by reset pin");
    do_read(1'b1, 1'b0, {1'b0, 13'h0002, 10'h001}, 16'h0002, 1'b0);
    do_read(1'b1, 1'b0, {1'b0, 13'h0004, 10'h20f}, 16'h0002, 1'b1);
    do_read(1'b0, 1'b1, {2'b00, 13'h0001, 9'h1ff}, 16'h0002, 1'b1);
    report_and_stop();
  end

  // Cut a hung run short
  initial begin
    #500000;
    failures++;
    report_and_stop();
  end
endmodule
